// >>> design/dsr_consts.vh
// constants for the dual 8-bit shift register block
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH

`define DSR_NUM_REGS 2
`define DSR_STAGES 8
`define DSR_STAGE_CLEAR 8'h00
`define DSR_INV_CLEAR 1'b1
`define DSR_SYNC_CLEAR 2'h0
`define DSR_FIFO_DEPTH 16
`define DSR_FIFO_AW 4
`define DSR_FIFO_WIDTH 18
`define DSR_WORD_MASK_LSB 16

`endif

// >>> design/dsr_shift.v
// dual 8-bit shift register with input mux, or-ed clocks, shared clear and snapshot fifo
//
// Functional notes
// (RQ1) two independent 8-bit shift registers, sixteen stages altogether
// (RQ2) each register clocks on the or of the shared and its own clock
// (RQ3) data is taken on the combined clock rising edge only
// (RQ4) all eight stages advance together; stage zero takes the selected input
// (RQ5) no further shift while either clock stays high
// (RQ6) outside logic holds one clock high to inhibit the register
// (RQ7) select low feeds the first source, select high the second
// (RQ8) a selected bit reaches the last stage after eight effective edges
// (RQ9) low clear zeroes all sixteen stages at once, overriding everything
// (RQ10) one clear input serves both registers
// (RQ11) last stage drives a true output and an inverted output
// (RQ12) combined clock edge detected on the system clock, one shift per edge
`timescale 1ns/1ns
`default_nettype none
`include "dsr_consts.vh"

// ----------------------------------------------------------------------------
// fifo: flip-flop storage, parameterised width and depth
// ----------------------------------------------------------------------------
module dsr_fifo #(
    parameter WIDTH = `DSR_FIFO_WIDTH,
    parameter DEPTH = `DSR_FIFO_DEPTH,
    parameter AW = `DSR_FIFO_AW
) (
    input wire core_clk_i,
    input wire resetn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // full and empty come straight from the occupancy count
    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointers and count; a pop and push together leave the count as is
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // storage needs no reset; nothing reads an entry before it is written
    always @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end
endmodule // dsr_fifo

// ----------------------------------------------------------------------------
// top: two shift registers behind synchronised pins
// ----------------------------------------------------------------------------
module dsr_shift (
    input wire core_clk_i,
    input wire resetn_i,
    input wire clear_all_low_i,
    input wire common_clock_pin_i,
    input wire [1:0] shift_clock_pin_i,
    input wire [1:0] source_select_i,
    input wire [1:0] first_source_in_i,
    input wire [1:0] second_source_in_i,
    output wire [1:0] last_stage_out_o,
    output wire [1:0] last_stage_inv_o,
    output wire snap_ready_o,
    output reg snap_drop_o,
    output wire snap_valid_o,
    input wire snap_ready_i,
    output wire [`DSR_FIFO_WIDTH-1:0] snap_data_o
);
    // ------------------------------------------------------------------------
    // clear and pin synchronisers
    // ------------------------------------------------------------------------
    // the clear acts without the clock, as the pin does on the real part
    wire clr_n;
    assign clr_n = resetn_i & clear_all_low_i; // RQ9 RQ10

    reg common_s1_r;
    reg common_s2_r;

    // common clock pin: two flops before anything reads it; kept out of the
    // clear so a clock held high through a clear cannot pose as a new edge
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            common_s1_r <= 1'b0;
            common_s2_r <= 1'b0;
        end else begin
            common_s1_r <= common_clock_pin_i;
            common_s2_r <= common_s1_r;
        end
    end

    // clear release brought onto the clock; no shift is taken while it runs
    reg [1:0] clr_run_r;
    always @(posedge core_clk_i or negedge clr_n) begin
        if (!clr_n) begin
            clr_run_r <= `DSR_SYNC_CLEAR;
        end else begin
            clr_run_r <= {clr_run_r[0], 1'b1};
        end
    end

    wire [1:0] comb_clk;
    wire [1:0] shift_en;
    wire [15:0] all_stages;

    genvar g;
    generate
        for (g = 0; g < `DSR_NUM_REGS; g = g + 1) begin : g_reg
            reg [1:0] own_s_r;
            reg [1:0] sel_s_r;
            reg [1:0] d0_s_r;
            reg [1:0] d1_s_r;
            reg comb_prev_r;
            reg [`DSR_STAGES-1:0] stage_r;
            reg inv_r;
            wire ser_in;
            wire [`DSR_STAGES-1:0] stage_nxt;

            // data and select share the clock's latency, so setup holds;
            // edge history follows the pins through a clear as well
            always @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    own_s_r <= `DSR_SYNC_CLEAR;
                    sel_s_r <= `DSR_SYNC_CLEAR;
                    d0_s_r <= `DSR_SYNC_CLEAR;
                    d1_s_r <= `DSR_SYNC_CLEAR;
                    comb_prev_r <= 1'b0;
                end else begin
                    own_s_r <= {own_s_r[0], shift_clock_pin_i[g]};
                    sel_s_r <= {sel_s_r[0], source_select_i[g]};
                    d0_s_r <= {d0_s_r[0], first_source_in_i[g]};
                    d1_s_r <= {d1_s_r[0], second_source_in_i[g]};
                    comb_prev_r <= comb_clk[g];
                end
            end

            // either input held high inhibits the other's pulses
            assign comb_clk[g] = common_s2_r | own_s_r[1]; // RQ2 RQ6
            // one shift per rising edge; high level alone does nothing
            assign shift_en[g] = comb_clk[g] & ~comb_prev_r & clr_run_r[1]; // RQ3 RQ5 RQ12
            // two-way input mux
            assign ser_in = sel_s_r[1] ? d1_s_r[1] : d0_s_r[1]; // RQ7
            // every stage moves on the same edge
            assign stage_nxt = {stage_r[`DSR_STAGES-2:0], ser_in}; // RQ4 RQ8

            // stages and inverted output; clear overrides all inputs
            always @(posedge core_clk_i or negedge clr_n) begin
                if (!clr_n) begin
                    stage_r <= `DSR_STAGE_CLEAR; // RQ9
                    inv_r <= `DSR_INV_CLEAR;
                end else begin
                    if (shift_en[g]) begin
                        stage_r <= stage_nxt; // RQ1 RQ4
                        inv_r <= ~stage_nxt[`DSR_STAGES-1]; // RQ11
                    end
                end
            end

            // true and inverted copies of the last stage, both from flops
            assign last_stage_out_o[g] = stage_r[`DSR_STAGES-1]; // RQ11
            assign last_stage_inv_o[g] = inv_r;
            assign all_stages[g*`DSR_STAGES +: `DSR_STAGES] = stage_r;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // snapshot stream
    // ------------------------------------------------------------------------
    // after every shift the two registers and the mask of which moved go out;
    // the pins cannot be stalled, so a full fifo drops the word and flags it
    reg snap_pend_r;
    reg [1:0] snap_mask_r;
    wire snap_in_ready;

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_pend_r <= 1'b0;
            snap_mask_r <= 2'h0;
            snap_drop_o <= 1'b0;
        end else begin
            snap_pend_r <= |shift_en;
            snap_mask_r <= shift_en;
            snap_drop_o <= snap_pend_r & ~snap_in_ready;
        end
    end

    assign snap_ready_o = snap_in_ready;

    dsr_fifo #(
        .WIDTH(`DSR_FIFO_WIDTH),
        .DEPTH(`DSR_FIFO_DEPTH),
        .AW(`DSR_FIFO_AW)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(snap_pend_r),
        .in_ready_o(snap_in_ready),
        .in_data_i({snap_mask_r, all_stages}),
        .out_valid_o(snap_valid_o),
        .out_ready_i(snap_ready_i),
        .out_data_o(snap_data_o)
    );
endmodule // dsr_shift
`default_nettype wire

// >>> dv/dsr_shift_chk.sv
// checker on the dual shift register top ports
`timescale 1ns/1ns
`default_nettype none
module dsr_shift_chk (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clear_all_low_i,
    input wire logic common_clock_pin_i,
    input wire logic [1:0] shift_clock_pin_i,
    input wire logic [1:0] last_stage_out_o,
    input wire logic [1:0] last_stage_inv_o,
    input wire logic snap_ready_o,
    input wire logic snap_drop_o,
    input wire logic snap_valid_o,
    input wire logic [17:0] snap_data_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // combined clock per register, seen at the pins, so shifts land a few cycles late
    wire logic [1:0] ck = shift_clock_pin_i | {2{common_clock_pin_i}};
    sequence s_idle(k); (!ck[k] && clear_all_low_i)[*5]; endsequence
    sequence s_busy0; (ck[0] && clear_all_low_i)[*6]; endsequence
    property p_inv; last_stage_inv_o == ~last_stage_out_o; endproperty
    property p_clr; !clear_all_low_i |-> last_stage_out_o == 2'h0; endproperty
    property p_hold0; s_busy0 |-> $stable(last_stage_out_o[0]); endproperty
    property p_idle0; s_idle(0) |-> $stable(last_stage_out_o[0]); endproperty
    property p_idle1; s_idle(1) |-> $stable(last_stage_out_o[1]); endproperty
    property p_once0;
        $changed(last_stage_out_o[0]) && clear_all_low_i |=> ($stable(last_stage_out_o[0]) || !clear_all_low_i)[*3];
    endproperty
    property p_mask; snap_valid_o |-> snap_data_o[17:16] != 2'h0; endproperty
    property p_drop; snap_drop_o |-> !$past(snap_ready_o); endproperty
    a_inv: assert property (p_inv) else $error("inverse output wrong");
    a_clr: assert property (p_clr) else $error("clear did not zero");
    a_hold0: assert property (p_hold0) else $error("shift while clock high");
    a_idle0: assert property (p_idle0) else $error("reg0 moved unclocked");
    a_idle1: assert property (p_idle1) else $error("reg1 moved unclocked");
    a_once0: assert property (p_once0) else $error("double shift");
    a_mask: assert property (p_mask) else $error("empty shift mask");
    a_drop: assert property (p_drop) else $error("drop without full");
endmodule // dsr_shift_chk
bind dsr_shift dsr_shift_chk u_chk (.core_clk_i, .resetn_i, .clear_all_low_i, .common_clock_pin_i,
    .shift_clock_pin_i, .last_stage_out_o, .last_stage_inv_o, .snap_ready_o, .snap_drop_o, .snap_valid_o, .snap_data_o);
`default_nettype wire

// >>> dv/dsr_sink.sv
// snapshot consumer model at the far side of the fifo
`timescale 1ns/1ns
`default_nettype none
module dsr_sink (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic stall_i,
    input wire logic snap_valid_i,
    output wire logic ready_o,
    output var int pops_o
);
    // a stalled consumer backs the fifo up until it refuses
    assign ready_o = !stall_i;
    always @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i) pops_o <= 0;
        else if (snap_valid_i && ready_o) pops_o <= pops_o + 1;
endmodule // dsr_sink
`default_nettype wire

// >>> dv/dsr_shift_tb.sv
// testbench for the dual shift register
`timescale 1ns/1ns
`default_nettype none
module dsr_shift_tb;
    logic core_clk_i = 0, resetn_i = 0, clear_all_low_i = 0, common_clock_pin_i = 0, stall = 0, snap_ready_i;
    logic [1:0] shift_clock_pin_i = 0, source_select_i = 0, first_source_in_i = 0, second_source_in_i = 0;
    logic [1:0] last_stage_out_o, last_stage_inv_o, hold = 0;
    logic snap_ready_o, snap_drop_o, snap_valid_o;
    logic [17:0] snap_data_o;
    int bad_count = 0, n_compared = 0, pops, cyc = 0, drops = 0;
    dsr_shift DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clear_all_low_i(clear_all_low_i),
        .common_clock_pin_i(common_clock_pin_i), .shift_clock_pin_i(shift_clock_pin_i),
        .source_select_i(source_select_i), .first_source_in_i(first_source_in_i),
        .second_source_in_i(second_source_in_i), .last_stage_out_o(last_stage_out_o),
        .last_stage_inv_o(last_stage_inv_o), .snap_ready_o(snap_ready_o), .snap_drop_o(snap_drop_o),
        .snap_valid_o(snap_valid_o), .snap_ready_i(snap_ready_i), .snap_data_o(snap_data_o));
    dsr_sink u_sink (.core_clk_i, .resetn_i, .stall_i(stall), .snap_valid_i(snap_valid_o), .ready_o(snap_ready_i),
        .pops_o(pops));
    always #5 core_clk_i = ~core_clk_i;
    // cycle ceiling and drop counting
    always @(posedge core_clk_i) begin
        cyc++;
        if (snap_drop_o === 1'b1) drops++;
        if (cyc == 3000) begin
            bad_count++;
            results;
        end
    end
    task automatic results;
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // one shift: pins held six cycles high; data flips mid-high, too late to be taken
    task automatic sh(input logic [1:0] ck, input logic cm, input logic [1:0] s, a, b);
        @(posedge core_clk_i);
        source_select_i <= s;
        first_source_in_i <= a;
        second_source_in_i <= b;
        shift_clock_pin_i <= ck | hold;
        common_clock_pin_i <= cm;
        repeat (2) @(posedge core_clk_i);
        first_source_in_i <= ~a;
        second_source_in_i <= ~b;
        repeat (4) @(posedge core_clk_i);
        shift_clock_pin_i <= hold;
        common_clock_pin_i <= 0;
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic t_mux;
        logic [15:0] w = 16'hb400;
        for (int i = 0; i < 16; i++) begin
            sh(2'b01, 0, {1'b0, i[0]}, {1'b0, w[15-i] ^ i[0]}, {1'b0, w[15-i] ^ !i[0]});
            if (i >= 7) chk(last_stage_out_o, {1'b0, w[22-i]});
        end
        chk(last_stage_inv_o, 2'b11);
    endtask
    task automatic t_common;
        for (int i = 1; i <= 8; i++) begin
            sh(2'b00, 1, 2'b10, 2'b01, 2'b10);
            chk(last_stage_out_o, (i == 8) ? 2'b11 : 2'b00);
        end
    endtask
    // clear with the shared clock high; the clock still high after release must not shift
    task automatic t_clear;
        int p0;
        p0 = pops;
        @(posedge core_clk_i);
        common_clock_pin_i <= 1;
        clear_all_low_i <= 0;
        repeat (2) @(posedge core_clk_i);
        chk(last_stage_out_o, 2'b00);
        chk(last_stage_inv_o, 2'b11);
        clear_all_low_i <= 1;
        repeat (4) @(posedge core_clk_i);
        common_clock_pin_i <= 0;
        repeat (4) @(posedge core_clk_i);
        chk(pops - p0, 0);
        chk(last_stage_out_o, 2'b00);
    endtask
    // own clock of register one raised before the pulses and held high to inhibit it
    task automatic t_inhibit;
        hold = 2'b10;
        @(posedge core_clk_i);
        shift_clock_pin_i <= hold;
        repeat (3) @(posedge core_clk_i);
        for (int i = 0; i < 8; i++) sh(2'b00, 1, 2'b00, 2'b11, 2'b11);
        chk(last_stage_out_o, 2'b01);
        hold = 2'b00;
        shift_clock_pin_i <= hold;
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic t_fifo;
        int p0;
        p0 = pops;
        stall <= 1;
        for (int i = 0; i < 18; i++) sh(2'b00, 1, 2'b00, 2'b00, 2'b00);
        chk(snap_ready_o, 0);
        chk(drops, 2);
        // head word: both moved, register one all zero, register zero ones with a zero shifted in
        chk(snap_data_o, 18'h300fe);
        stall <= 0;
        repeat (40) @(posedge core_clk_i);
        chk(pops - p0, 16);
        chk(snap_valid_o, 0);
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1;
        clear_all_low_i <= 1;
        repeat (2) @(posedge core_clk_i);
        t_mux;
        t_common;
        t_clear;
        t_inhibit;
        t_fifo;
        results;
    end
endmodule // dsr_shift_tb
`default_nettype wire
